// ==== core/fpcs_host.sv ====
// host controller that drives the flash command pins from wishbone orders
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module fpcs_host #(
  parameter int ADDR_W = 22,
  parameter logic [21:0] UNLOCK_A1 = 22'h000555,
  parameter logic [21:0] UNLOCK_A2 = 22'h0002aa,
  parameter logic [7:0] UNLOCK_D1 = 8'haa,
  parameter logic [7:0] UNLOCK_D2 = 8'h55,
  parameter logic [7:0] CMD_PGM = 8'ha0,
  parameter logic [7:0] CMD_IDQ = 8'h90,
  parameter logic [7:0] CMD_RST = 8'hf0,
  parameter logic [15:0] POLL_LIMIT = 16'hffff
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash pins
  output logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  input wire logic done_pin,
  output logic sector_zero_guard_n,
  output logic accel_voltage_pin
);
  typedef enum logic [3:0] {
    FP_IDLE = 4'h0,
    FP_SETUP = 4'h1,
    FP_WLOW = 4'h3,
    FP_WHIGH = 4'h2,
    FP_NEXT = 4'h6,
    FP_RSETUP = 4'h7,
    FP_RLOW = 4'h5,
    FP_POLL = 4'h4,
    FP_WAIT = 4'hc
  } fpcs_state_e;

  typedef struct packed {
    fpcs_state_e st;
    logic [2:0] op;
    logic [1:0] step;
    logic [9:0] cnt;
    logic [15:0] polls;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    logic done;
    logic fail;
    logic susp;
    logic ident;
    logic refused;
    logic early;
    logic [9:0] since_pgm;
    logic guard_n;
    logic accel;
    logic ack;
    logic [31:0] dat;
    logic [21:0] paddr;
    logic pend;
    logic [21:0] f_addr;
    logic [15:0] f_dq;
    logic f_oe_n;
    logic f_ce_n;
    logic f_we_n;
    logic f_og_n;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic rdy_s1;
    logic rdy_s2;
  } fpcs_s;

  fpcs_s r;
  fpcs_s n;

  // index of the last bus write in each ordered sequence
  function automatic logic [1:0] last_step(input logic [2:0] op);
    case (op)
      fpcs_pkg::OP_PROGRAM: last_step = 2'd3;
      fpcs_pkg::OP_IDENT: last_step = 2'd2;
      default: last_step = 2'd0;
    endcase
  endfunction

  // address and data of each write of a sequence
  function automatic logic [37:0] seq_word(input logic [2:0] op, input logic [1:0] step,
                                           input logic [21:0] a, input logic [15:0] d);
    logic [7:0] code;
    code = 8'h00;
    if (step == 2'd0) begin
      seq_word = {UNLOCK_A1, 8'h00, UNLOCK_D1};
    end else if (step == 2'd1) begin
      seq_word = {UNLOCK_A2, 8'h00, UNLOCK_D2};
    end else if (step == 2'd3) begin
      seq_word = {a, d};
    end else begin
      code = (op == fpcs_pkg::OP_PROGRAM) ? CMD_PGM : CMD_IDQ;
      seq_word = {UNLOCK_A1, 8'h00, code};
    end
    // single-write commands
    case (op)
      fpcs_pkg::OP_RESET: seq_word = {a, 8'h00, CMD_RST};
      fpcs_pkg::OP_SUSPEND: seq_word = {a, 8'h00, fpcs_pkg::CMD_SUSPEND};
      fpcs_pkg::OP_RESUME: seq_word = {a, 8'h00, fpcs_pkg::CMD_RESUME};
      default: begin
      end
    endcase
  endfunction

  always_comb begin
    logic [2:0] req;
    logic acc;
    logic [37:0] w;
    req = 3'h0;
    acc = 1'b0;
    w = 38'h0;
    n = r;
    n.ack = 1'b0;
    n.dq_s1 = flash_dq_in;
    n.dq_s2 = r.dq_s1;
    n.rdy_s1 = done_pin;
    n.rdy_s2 = r.rdy_s1;
    if (r.since_pgm != 10'h3ff) begin
      n.since_pgm = r.since_pgm + 10'd1;
    end
    // classic wishbone: one-cycle ack, then ack drops
    acc = wb_cyc_i && wb_stb_i && !r.ack;
    if (acc) begin
      n.ack = 1'b1;
      n.dat = 32'h0;
      case (wb_adr_i)
        fpcs_pkg::REG_CTRL: begin
          if (wb_we_i && wb_sel_i[0]) begin
            req = wb_dat_i[2:0];
          end
        end
        fpcs_pkg::REG_ADDR: begin
          if (wb_we_i && wb_sel_i[0]) n.addr[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) n.addr[15:8] = wb_dat_i[15:8];
          if (wb_we_i && wb_sel_i[2]) n.addr[21:16] = wb_dat_i[21:16];
          n.dat = {10'h0, r.addr};
        end
        fpcs_pkg::REG_WDATA: begin
          if (wb_we_i && wb_sel_i[0]) n.wdata[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) n.wdata[15:8] = wb_dat_i[15:8];
          n.dat = {16'h0, r.wdata};
        end
        fpcs_pkg::REG_STATUS: begin
          n.dat = {26'h0, r.refused, r.ident, r.susp, r.fail, r.done, r.busy};
          // writing ones clears done, fail and refused
          if (wb_we_i && wb_sel_i[0]) begin
            n.done = r.done & ~wb_dat_i[fpcs_pkg::ST_DONE];
            n.fail = r.fail & ~wb_dat_i[fpcs_pkg::ST_FAIL];
            n.refused = r.refused & ~wb_dat_i[fpcs_pkg::ST_REFUSED];
          end
        end
        fpcs_pkg::REG_RDATA: n.dat = {16'h0, r.rdata};
        fpcs_pkg::REG_PINS: begin
          // guard and accel levels may not change while a program runs
          if (wb_we_i && wb_sel_i[0] && !r.busy) begin
            n.guard_n = wb_dat_i[fpcs_pkg::PIN_GUARD];
            n.accel = wb_dat_i[fpcs_pkg::PIN_ACCEL];
          end
          n.dat = {29'h0, r.rdy_s2, r.accel, r.guard_n};
        end
        default: n.dat = 32'h0;
      endcase
    end
    // accept a new order only when idle and the order is legal now; a suspend while busy, not suspended and none held is held instead, except in the FP_POLL cycle
    if (req != fpcs_pkg::OP_NONE) begin
      if (req == fpcs_pkg::OP_SUSPEND && r.busy && !r.susp && !r.pend && r.st != FP_IDLE) begin
        // a suspend during a poll read is held until that read ends; one arriving in the FP_POLL cycle is dropped
        n.pend = 1'b1;
      end else if (r.st != FP_IDLE ||
          (req == fpcs_pkg::OP_PROGRAM && (r.susp || r.ident)) ||
          (req == fpcs_pkg::OP_IDENT && r.ident) ||
          (req == fpcs_pkg::OP_SUSPEND && (!r.busy || r.susp)) ||
          (req == fpcs_pkg::OP_RESUME && !r.susp)) begin
        n.refused = 1'b1;
      end else begin
        n.op = req;
        n.step = 2'd0;
        n.cnt = 10'd0;
        n.st = (req == fpcs_pkg::OP_READ) ? FP_RSETUP : FP_SETUP;
        if (req != fpcs_pkg::OP_READ) n.done = 1'b0;
      end
    end
    case (r.st)
      FP_IDLE: begin
      end
      FP_SETUP: begin
        w = seq_word(r.op, r.step, r.busy ? r.paddr : r.addr, r.wdata);
        n.f_addr = w[37:16];
        // command words carry a zero upper byte, program data is a full word
        n.f_dq = w[15:0];
        n.f_oe_n = 1'b0;
        n.f_og_n = 1'b1;
        n.f_ce_n = 1'b0;
        n.cnt = r.cnt + 10'd1;
        if (r.cnt >= 10'(fpcs_pkg::SETUP_CYC)) begin
          n.cnt = 10'd0;
          n.st = FP_WLOW;
        end
      end
      FP_WLOW: begin
        // address is stable before the strobe falls, data held past its rise
        n.f_we_n = 1'b0;
        n.cnt = r.cnt + 10'd1;
        if (r.cnt >= 10'(fpcs_pkg::STROBE_CYC)) begin
          n.cnt = 10'd0;
          n.f_we_n = 1'b1;
          n.st = FP_WHIGH;
        end
      end
      FP_WHIGH: begin
        n.cnt = r.cnt + 10'd1;
        if (r.cnt >= 10'(fpcs_pkg::SETUP_CYC)) begin
          n.cnt = 10'd0;
          n.f_ce_n = 1'b1;
          n.f_oe_n = 1'b1;
          n.st = FP_NEXT;
        end
      end
      FP_NEXT: begin
        if (r.step != last_step(r.op)) begin
          n.step = r.step + 2'd1;
          n.st = FP_SETUP;
        end else begin
          n.st = FP_IDLE;
          n.done = 1'b1;
          case (r.op)
            fpcs_pkg::OP_PROGRAM: begin
              n.busy = 1'b1;
              n.done = 1'b0;
              n.polls = 16'h0;
              n.since_pgm = 10'd0;
              n.early = 1'b0;
              n.f_addr = r.addr;
              n.paddr = r.addr;
              n.st = FP_RSETUP;
            end
            fpcs_pkg::OP_IDENT: n.ident = 1'b1;
            fpcs_pkg::OP_RESET: begin
              // leaving identity mode within a suspend keeps the suspend
              if (r.ident) begin
                n.ident = 1'b0;
              end else begin
                n.busy = 1'b0;
                n.susp = 1'b0;
              end
              n.fail = 1'b0;
            end
            fpcs_pkg::OP_SUSPEND: begin
              n.susp = 1'b1;
              n.early = (r.since_pgm < 10'(fpcs_pkg::EARLY_SUSP_CYC));
              n.cnt = 10'd0;
              n.done = 1'b0;
              n.st = FP_WAIT;
            end
            fpcs_pkg::OP_RESUME: begin
              n.susp = 1'b0;
              n.done = 1'b0;
              n.cnt = 10'd0;
              n.st = r.early ? FP_WAIT : FP_RSETUP;
            end
            default: begin
            end
          endcase
        end
      end
      FP_WAIT: begin
        n.cnt = r.cnt + 10'd1;
        if (r.susp && r.cnt >= 10'(fpcs_pkg::SUSP_HALT_CYC)) begin
          n.cnt = 10'd0;
          n.done = 1'b1;
          n.st = FP_IDLE;
        end else if (!r.susp && r.cnt >= 10'(fpcs_pkg::RESUME_WAIT_CYC)) begin
          n.cnt = 10'd0;
          n.early = 1'b0;
          n.st = FP_RSETUP;
        end
      end
      FP_RSETUP: begin
        n.f_addr = (r.busy && !r.susp) ? r.paddr : r.addr;
        n.f_we_n = 1'b1;
        n.f_oe_n = 1'b1;
        n.f_ce_n = 1'b0;
        n.f_og_n = 1'b0;
        n.cnt = 10'd0;
        n.st = FP_RLOW;
      end
      FP_RLOW: begin
        n.cnt = r.cnt + 10'd1;
        // two sampling flops plus access time
        if (r.cnt >= 10'(fpcs_pkg::STROBE_CYC + 2)) begin
          n.cnt = 10'd0;
          n.rdata = r.dq_s2;
          n.f_og_n = 1'b1;
          n.f_ce_n = 1'b1;
          n.st = (r.busy && !r.susp) ? FP_POLL : FP_IDLE;
          if (!r.busy || r.susp) n.done = 1'b1;
        end
      end
      FP_POLL: begin
        n.pend = 1'b0;
        if (r.rdata[fpcs_pkg::POLL_BIT] == r.wdata[fpcs_pkg::POLL_BIT]) begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = FP_IDLE;
        end else if (r.rdata[fpcs_pkg::TLIMIT_BIT] || r.polls == POLL_LIMIT) begin
          // error stays until software clears it in status or issues the reset order
          n.busy = 1'b0;
          n.fail = 1'b1;
          n.st = FP_IDLE;
        end else if (r.pend) begin
          // send the held suspend as a single command write
          n.op = fpcs_pkg::OP_SUSPEND;
          n.step = 2'd0;
          n.st = FP_SETUP;
        end else begin
          n.polls = r.polls + 16'h1;
          n.st = FP_RSETUP;
        end
      end
      default: n.st = FP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: FP_IDLE, op: 3'h0, step: 2'd0, cnt: 10'd0, polls: 16'h0,
             addr: 22'h0, wdata: 16'h0, rdata: 16'h0, busy: 1'b0, done: 1'b0,
             fail: 1'b0, susp: 1'b0, ident: 1'b0, refused: 1'b0, early: 1'b0,
             since_pgm: 10'h3ff, guard_n: 1'b1, accel: 1'b0, ack: 1'b0,
             dat: 32'h0, f_addr: 22'h0, f_dq: 16'h0, f_oe_n: 1'b1, f_ce_n: 1'b1,
             f_we_n: 1'b1, f_og_n: 1'b1, dq_s1: 16'h0, dq_s2: 16'h0,
             rdy_s1: 1'b1, rdy_s2: 1'b1, paddr: 22'h0, pend: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign flash_addr = r.f_addr;
  assign flash_dq_out = r.f_dq;
  assign flash_dq_oe_n = r.f_oe_n;
  assign chip_select_n = r.f_ce_n;
  assign write_strobe_n = r.f_we_n;
  assign output_gate_n = r.f_og_n;
  assign sector_zero_guard_n = r.guard_n;
  assign accel_voltage_pin = r.accel;
endmodule

// ==== core/fpcs_pkg.sv ====
// package for the flash program command sequencer host controller
package fpcs_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // ctrl command codes (written to REG_CTRL bits 2:0)
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_RESET = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  localparam logic [2:0] OP_IDENT = 3'h4;
  localparam logic [2:0] OP_SUSPEND = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SUSP = 3;
  localparam int ST_IDENT = 4;
  localparam int ST_REFUSED = 5;
  // pins register bit positions
  localparam int PIN_GUARD = 0;
  localparam int PIN_ACCEL = 1;
  // flash data bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TLIMIT_BIT = 5;
  // command data codes (low byte only)
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  // identity query addresses
  localparam logic [21:0] ID_MAKER = 22'h000000;
  localparam logic [21:0] ID_DEVICE = 22'h000001;
  localparam logic [21:0] ID_EXT0 = 22'h00000e;
  localparam logic [21:0] ID_EXT1 = 22'h00000f;
  // bus strobe, suspend and resume timing
  localparam int CLK_MHZ = 200;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_NS = 10;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int RESUME_WAIT_US = 4;
  localparam int RESUME_WAIT_CYC = RESUME_WAIT_US * CLK_MHZ;
  localparam int EARLY_SUSP_US = 4;
  localparam int EARLY_SUSP_CYC = EARLY_SUSP_US * CLK_MHZ;
  localparam int SUSP_HALT_US = 1;
  localparam int SUSP_HALT_CYC = SUSP_HALT_US * CLK_MHZ;
endpackage

// ==== dv/fpcs_flash_model.sv ====
// behavioural flash: command decoder, program timer, suspend and identity modes
`timescale 1ns/10ps
module fpcs_flash_model #(
  parameter int PGM_NS = 10000,
  parameter logic [15:0] MAKER = 16'h005a, // arbitrary value
  parameter logic [15:0] DEVICE = 16'h1c3d, // arbitrary value
  parameter logic [15:0] EXT0 = 16'h0a11, // arbitrary value
  parameter logic [15:0] EXT1 = 16'h0b22 // arbitrary value
) (
  // pins from the host
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic sector_zero_guard_n,
  input wire logic accel_voltage_pin,
  // pins to the host
  output logic [15:0] flash_dq_in,
  output logic done_pin
);
  logic [15:0] mem [int];
  logic [21:0] la = '0;
  logic [21:0] pa = '0;
  logic [15:0] pd = '0;
  logic [15:0] q = '0;
  logic [7:0] c;
  int step = 0;
  int tleft = 0;
  bit busy = 0;
  bit susp = 0;
  bit idm = 0;
  bit tog = 0;
  bit tl = 0;
  bit blk;
  function automatic logic [15:0] arr(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  always @(negedge write_strobe_n) la = flash_addr;
  // a write without select or with the read gate low decodes as no command
  always @(posedge write_strobe_n) begin
    c = (!chip_select_n && output_gate_n) ? flash_dq_out[7:0] : 8'h00;
    if (c == 8'hf0 && (!busy || susp || tl)) begin
      step = 0;
      idm = 0;
      busy = busy && !tl;
      tl = 0;
    end else if (busy && !susp) begin
      if (c == 8'hb0) susp = 1;
    end else if (susp && c == 8'h30) begin
      susp = 0;
      step = 0;
    end else if (step == 3) begin
      step = 0;
      pa = la;
      pd = flash_dq_out;
      blk = pa < 22'h008000 && !sector_zero_guard_n;
      blk = blk || (pa[21] && sector_zero_guard_n && !accel_voltage_pin);
      busy = !blk;
      tl = !blk && |(pd & ~arr(pa));
      tleft = accel_voltage_pin ? PGM_NS * 85 / 100 : PGM_NS;
    end else if (step == 0 && la == 22'h000555 && c == 8'haa) begin
      step = 1;
    end else if (step == 1 && la == 22'h0002aa && c == 8'h55) begin
      step = 2;
    end else if (step == 2 && c == 8'ha0 && !susp && !idm) begin
      step = 3;
    end else if (step == 2 && c == 8'h90) begin
      step = 0;
      idm = 1;
    end else begin
      step = 0;
    end
  end
  // a program that tries to raise a bit hangs until reset
  always begin
    #10;
    if (busy && !susp && !tl) begin
      tleft = tleft - 10;
      if (tleft <= 0) begin
        mem[pa] = arr(pa) & pd;
        busy = 0;
      end
    end
  end
  always @(negedge output_gate_n) tog = ~tog;
  always begin
    #1;
    done_pin = !busy || susp;
    if (!chip_select_n && !output_gate_n) begin
      if (busy && !susp) q = {8'h00, ~pd[7], tog, tl, 5'h00};
      else if (susp && flash_addr == pa) q = ~pd;
      else q = arr(flash_addr);
      if (idm && flash_addr == 22'h000000) q = MAKER;
      if (idm && flash_addr == 22'h000001) q = DEVICE;
      if (idm && flash_addr == 22'h00000e) q = EXT0;
      if (idm && flash_addr == 22'h00000f) q = EXT1;
      flash_dq_in = q;
    end else begin
      flash_dq_in = ~q;
    end
  end
endmodule

// ==== dv/fpcs_host_chk.sv ====
// assertions on the flash host controller bus and flash pins
`timescale 1ns/10ps
module fpcs_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // flash pins
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic sector_zero_guard_n,
  input wire logic accel_voltage_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_we_sel; !write_strobe_n |-> !chip_select_n && output_gate_n; endproperty
  a_we_sel: assert property (p_we_sel) else $error("write strobe outside select");
  property p_we_drv; !write_strobe_n |-> !flash_dq_oe_n; endproperty
  a_we_drv: assert property (p_we_drv) else $error("data not driven in write");
  property p_rd_sel; !output_gate_n |-> flash_dq_oe_n && !chip_select_n; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read gate with bus driven");
  property p_stable; !write_strobe_n && $past(!write_strobe_n) |-> $stable(flash_addr)
    && $stable(flash_dq_out); endproperty
  a_stable: assert property (p_stable) else $error("address or data moved in write");
  property p_ce_first; $fell(write_strobe_n) |-> $past(!chip_select_n, 2); endproperty
  a_ce_first: assert property (p_ce_first) else $error("select too late before write");
  property p_we_width; $fell(write_strobe_n) |-> !write_strobe_n [*8]; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short");
  property p_ce_hold; $rose(write_strobe_n) |-> !chip_select_n [*2]; endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("select rose with write strobe");
  property p_pins; $changed(accel_voltage_pin) || $changed(sector_zero_guard_n)
    |-> chip_select_n; endproperty
  a_pins: assert property (p_pins) else $error("level pin moved during access");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle pulse");
endmodule
bind fpcs_host fpcs_chk u_fpcs_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
  .sector_zero_guard_n(sector_zero_guard_n), .accel_voltage_pin(accel_voltage_pin));

// ==== dv/fpcs_host_tb.sv ====
// testbench of the flash host controller against the behavioural flash
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module fpcs_host_tb;
  localparam logic [15:0] IDV [4] = '{16'h005a, 16'h1c3d, 16'h0a11, 16'h0b22};
  localparam logic [21:0] IDA [4] = '{22'h0, 22'h1, 22'he, 22'hf};
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, done_pin, guard_n, accel;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [21:0] fa;
  logic [15:0] dq_in, dq_out;
  logic dq_oe_n, ce_n, we_n, og_n;
  int miscompares = 0, comparisons = 0, cyc = 0, n, n1;
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  fpcs_host #(.POLL_LIMIT(16'h0200)) u_fpcs_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_addr(fa), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
    .chip_select_n(ce_n), .write_strobe_n(we_n), .output_gate_n(og_n), .done_pin(done_pin),
    .sector_zero_guard_n(guard_n), .accel_voltage_pin(accel));
  fpcs_flash_model u_fpcs_flash_model (.flash_addr(fa), .flash_dq_out(dq_out),
    .chip_select_n(ce_n), .write_strobe_n(we_n), .output_gate_n(og_n),
    .sector_zero_guard_n(guard_n), .accel_voltage_pin(accel), .flash_dq_in(dq_in),
    .done_pin(done_pin));
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  // poll status until done, fail or refused shows up
  task automatic wt();
    int k;
    k = 0;
    do begin
      wb(fpcs_pkg::REG_STATUS, 1'b0, 32'h0);
      k++;
    end while ((q & 32'h26) == 0 && k < 9000);
  endtask
  task automatic op(input logic [2:0] c, input logic [4:0] e, input string s);
    int t;
    t = cyc;
    wb(fpcs_pkg::REG_CTRL, 1'b1, {29'h0, c});
    wt();
    n = cyc - t;
    `CHK(s, e, q[5:1]);
    wb(fpcs_pkg::REG_STATUS, 1'b1, 32'h26);
  endtask
  task automatic fr(input logic [21:0] a, input logic [4:0] e, input logic [15:0] x,
    input string s);
    wb(fpcs_pkg::REG_ADDR, 1'b1, {10'h0, a});
    op(fpcs_pkg::OP_READ, e, s);
    wb(fpcs_pkg::REG_RDATA, 1'b0, 32'h0);
    `CHK(s, x, q[15:0]);
  endtask
  task automatic pg(input logic [21:0] a, input logic [15:0] d, input logic [4:0] e,
    input string s);
    wb(fpcs_pkg::REG_ADDR, 1'b1, {10'h0, a});
    wb(fpcs_pkg::REG_WDATA, 1'b1, {16'h0, d});
    op(fpcs_pkg::OP_PROGRAM, e, s);
  endtask
  task automatic t_basic();
    wb(fpcs_pkg::REG_PINS, 1'b0, 32'h0);
    `CHK("pins", 3'b101, q[2:0]);
    wb(8'h40, 1'b1, 32'hffffffff);
    wb(8'h40, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, q);
    fr(22'h000100, 5'b00001, 16'hffff, "power_read");
    op(fpcs_pkg::OP_SUSPEND, 5'b10000, "susp_idle");
    op(fpcs_pkg::OP_RESUME, 5'b10000, "resume_idle");
    $display("test basic finished");
  endtask
  task automatic t_program();
    pg(22'h001234, 16'h12a5, 5'b00001, "pgm");
    n1 = n;
    `CHK("pgm_time", 1'b1, n1 > 2000);
    fr(22'h001234, 5'b00001, 16'h12a5, "pgm_rd");
    wb(fpcs_pkg::REG_PINS, 1'b1, 32'h3);
    `CHK("accel_pin", 1'b1, accel);
    pg(22'h200010, 16'h0f0f, 5'b00001, "acc_pgm");
    `CHK("acc_time", 1'b1, n < n1);
    fr(22'h200010, 5'b00001, 16'h0f0f, "acc_rd");
    wb(fpcs_pkg::REG_PINS, 1'b1, 32'h1);
    pg(22'h200020, 16'h0f0f, 5'b00010, "prot_pgm");
    wb(fpcs_pkg::REG_PINS, 1'b1, 32'h0);
    `CHK("guard_pin", 1'b0, guard_n);
    pg(22'h000040, 16'h0000, 5'b00010, "guard_blk");
    pg(22'h200030, 16'h0f0f, 5'b00001, "guard_lift");
    wb(fpcs_pkg::REG_PINS, 1'b1, 32'h1);
    pg(22'h001234, 16'hffff, 5'b00010, "raise_bit");
    op(fpcs_pkg::OP_RESET, 5'b00001, "limit_exit");
    fr(22'h001234, 5'b00001, 16'h12a5, "limit_rd");
    $display("test program finished");
  endtask
  task automatic t_ident();
    op(fpcs_pkg::OP_IDENT, 5'b01001, "ident");
    for (int i = 0; i < 4; i++) fr(IDA[i], 5'b01001, IDV[i], "id_code");
    fr(22'h001234, 5'b01001, 16'h12a5, "id_array");
    op(fpcs_pkg::OP_IDENT, 5'b11000, "id_again");
    op(fpcs_pkg::OP_RESET, 5'b00001, "id_exit");
    $display("test ident finished");
  endtask
  task automatic t_suspend();
    logic [4:0] r;
    int t;
    wb(fpcs_pkg::REG_ADDR, 1'b1, 32'h300);
    wb(fpcs_pkg::REG_WDATA, 1'b1, 32'ha0);
    wb(fpcs_pkg::REG_CTRL, 1'b1, {29'h0, fpcs_pkg::OP_PROGRAM});
    t = cyc;
    // suspend is refused during the command writes, so retry while it is refused
    do begin
      wb(fpcs_pkg::REG_CTRL, 1'b1, {29'h0, fpcs_pkg::OP_SUSPEND});
      wt();
      r = q[5:1];
      wb(fpcs_pkg::REG_STATUS, 1'b1, 32'h20);
    end while (r[4] && cyc - t < 2000);
    `CHK("susp", 5'b00101, r);
    wb(fpcs_pkg::REG_STATUS, 1'b1, 32'h26);
    fr(22'h001234, 5'b00101, 16'h12a5, "susp_rd");
    op(fpcs_pkg::OP_IDENT, 5'b01101, "susp_id");
    fr(IDA[0], 5'b01101, IDV[0], "susp_maker");
    op(fpcs_pkg::OP_RESET, 5'b00101, "susp_id_exit");
    op(fpcs_pkg::OP_SUSPEND, 5'b10100, "susp_again");
    op(fpcs_pkg::OP_PROGRAM, 5'b10100, "susp_pgm");
    op(fpcs_pkg::OP_RESUME, 5'b00001, "resume");
    `CHK("resume_wait", 1'b1, n >= 800);
    fr(22'h000300, 5'b00001, 16'h00a0, "resume_rd");
    $display("test suspend finished");
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_basic();
    t_program();
    t_ident();
    t_suspend();
    conclude();
  end
  // the whole sequence needs well under half of this span
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
